// *** rtl/sarhc_ctrl.sv ***
// Host controller that drives a 14-bit converter through its parallel pins.
// Assumes one 200 MHz clock and a software register port with reads of one cycle latency.
// Functional notes
// - Sleep selects drive light or deep sleep.
// - Wait 300 ns after light sleep.
// - Light sleep only with external reference.
// - Internal reference: wait 500 ms after deep.
// - External reference: wait 80 us after deep.
// - Offset writes limited to plus-minus 1310.
// - Offset in low 12 bits, top zero.
// - Mode straps 01 immediate, 10 deferred.
// - Never read during conversion.
// - Leave a quiet gap before converting.
// - Start falling edge begins conversion.
// - Offset is two's complement.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sarhc_ctrl #(
  parameter int unsigned DEEP_INT_WAIT = sarhc_pkg::DEEP_INT_CYC,
  parameter int unsigned DEEP_EXT_WAIT = sarhc_pkg::DEEP_EXT_CYC
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Software register port.
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Converter control pins.
  output logic sample_start_n_out,
  input wire logic busy_n_in,
  output logic chip_select_n_out,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out,
  output logic light_sleep_select_out,
  output logic deep_sleep_select_out,
  output logic saturate_enable_out,
  output logic iface_sel_hi_out,
  output logic iface_sel_lo_out,
  // Converter two-way data bus.
  input wire logic [14:0] data_bus_in,
  output logic [14:0] data_bus_out,
  output logic data_bus_oe_out
);
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_WAKE  = 7'b000_0010,
    ST_START = 7'b000_0100,
    ST_CONV  = 7'b000_1000,
    ST_READ  = 7'b001_0000,
    ST_WRITE = 7'b010_0000,
    ST_QUIET = 7'b100_0000
  } sarhc_state_t;

  sarhc_state_t state;
  logic [5:0] ctrl;
  logic [11:0] offset;
  logic [14:0] result;
  logic [15:0] count;
  logic early;
  logic timeout;
  logic pend_start;
  logic pend_write;
  logic [31:0] wait_cnt;
  logic [31:0] wake_cnt;
  logic [7:0] step_cnt;
  logic busy_n;
  logic busy_d;
  logic light_q;
  logic deep_q;

  // Busy comes from the converter's own oscillator domain.
  sarhc_sync #(
    .WIDTH(1)
  ) u_busy_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .pin_in(busy_n_in),
    .clean_out(busy_n)
  );

  function automatic logic offset_ok(input logic [11:0] v);
    int sv;
    sv = int'(signed'(v));
    return (sv >= sarhc_pkg::OFFSET_MIN) && (sv <= sarhc_pkg::OFFSET_MAX);
  endfunction

  // Control register; light sleep is refused without an external reference.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ctrl <= sarhc_pkg::CTRL_RESET;
    end else if (reg_wr_in && reg_addr_in == sarhc_pkg::REG_CTRL) begin
      ctrl <= reg_wdata_in[5:0];
      ctrl[sarhc_pkg::CTRL_LIGHT] <= reg_wdata_in[sarhc_pkg::CTRL_LIGHT] &&
                                     reg_wdata_in[sarhc_pkg::CTRL_EXTREF];
    end
  end

  // Offset shadow; out-of-range values are dropped so the device never sees them.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      offset <= sarhc_pkg::OFFSET_RESET;
    end else if (reg_wr_in && reg_addr_in == sarhc_pkg::REG_OFFSET &&
                 offset_ok(reg_wdata_in[11:0])) begin
      offset <= reg_wdata_in[11:0];
    end
  end

  // Pending requests; a new request in ST_START or ST_WRITE is kept only if it lands in the last cycle.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pend_start <= 1'b0;
      pend_write <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == sarhc_pkg::REG_CTRL &&
          reg_wdata_in[sarhc_pkg::CTRL_START]) begin
        pend_start <= 1'b1;
      end else if (state == ST_START) begin
        pend_start <= 1'b0;
      end
      if (reg_wr_in && reg_addr_in == sarhc_pkg::REG_OFFSET &&
          offset_ok(reg_wdata_in[11:0])) begin
        pend_write <= 1'b1;
      end else if (state == ST_WRITE) begin
        pend_write <= 1'b0;
      end
    end
  end

  // Sleep pins follow the control bits; exits load the wake-up wait.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      light_q <= 1'b0;
      deep_q <= 1'b0;
      wake_cnt <= 32'h0000_0000;
    end else begin
      light_q <= ctrl[sarhc_pkg::CTRL_LIGHT];
      deep_q <= ctrl[sarhc_pkg::CTRL_DEEP];
      if (deep_q && !ctrl[sarhc_pkg::CTRL_DEEP]) begin
        wake_cnt <= ctrl[sarhc_pkg::CTRL_EXTREF] ? DEEP_EXT_WAIT : DEEP_INT_WAIT;
      end else if (light_q && !ctrl[sarhc_pkg::CTRL_LIGHT]) begin
        wake_cnt <= sarhc_pkg::LIGHT_WAKE_CYC;
      end else if (wake_cnt != 32'h0000_0000) begin
        wake_cnt <= wake_cnt - 32'h0000_0001;
      end
    end
  end

  assign light_sleep_select_out = light_q;
  assign deep_sleep_select_out = deep_q;
  assign saturate_enable_out = ctrl[sarhc_pkg::CTRL_SAT];
  assign iface_sel_hi_out = ctrl[sarhc_pkg::CTRL_DEFER];
  assign iface_sel_lo_out = !ctrl[sarhc_pkg::CTRL_DEFER];

  // Busy edge detect on the settled copy.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      busy_d <= 1'b1;
    end else begin
      busy_d <= busy_n;
    end
  end

  // Sequencer: wake wait, start pulse, conversion, readout, quiet gap.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      step_cnt <= 8'h00;
      wait_cnt <= 32'h0000_0000;
      early <= 1'b0;
      timeout <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          step_cnt <= 8'h00;
          if (pend_write) begin
            state <= ST_WRITE;
          end else if (pend_start && !light_q && !deep_q) begin
            state <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (wake_cnt == 32'h0000_0000 && !light_q && !deep_q &&
              !ctrl[sarhc_pkg::CTRL_LIGHT] && !ctrl[sarhc_pkg::CTRL_DEEP]) begin
            state <= ST_START;
          end
        end
        ST_START: begin
          early <= (wake_cnt != 32'h0000_0000) || light_q || deep_q;
          step_cnt <= step_cnt + 8'h01;
          if (step_cnt == 8'(sarhc_pkg::START_LOW_CYC - 1)) begin
            state <= ST_CONV;
            step_cnt <= 8'h00;
            wait_cnt <= 32'h0000_0000;
          end
        end
        ST_CONV: begin
          wait_cnt <= wait_cnt + 32'h0000_0001;
          timeout <= 1'b0;
          if (busy_n && !busy_d) begin
            state <= ST_READ;
          end else if (wait_cnt == 32'(sarhc_pkg::TIMEOUT_CYC)) begin
            timeout <= 1'b1;
            state <= ST_QUIET;
          end
        end
        ST_READ, ST_WRITE: begin
          step_cnt <= step_cnt + 8'h01;
          if (step_cnt == 8'(sarhc_pkg::STROBE_CYC - 1)) begin
            state <= ST_QUIET;
            step_cnt <= 8'h00;
          end
        end
        ST_QUIET: begin
          step_cnt <= step_cnt + 8'h01;
          if (step_cnt == 8'(sarhc_pkg::QUIET_CYC - 1)) begin
            state <= ST_IDLE;
            step_cnt <= 8'h00;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Captured result; the converter presents it as received.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      result <= 15'h0000;
      count <= 16'h0000;
    end else if (state == ST_READ && step_cnt == 8'(sarhc_pkg::STROBE_CYC - 1)) begin
      result <= data_bus_in;
      count <= count + 16'h0001;
    end
  end

  // Pin drive; the bus is released whenever the host is not writing.
  assign sample_start_n_out = (state != ST_START);
  assign chip_select_n_out = !(state == ST_READ || state == ST_WRITE);
  assign read_strobe_n_out = (state != ST_READ);
  assign write_strobe_n_out = (state != ST_WRITE);
  assign data_bus_oe_out = (state == ST_WRITE);
  assign data_bus_out = {3'b000, offset};

  // Register reads, one cycle later; unmapped offsets read zero.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_addr_in == sarhc_pkg::REG_CTRL) begin
      reg_rdata_out <= {26'h000_0000, ctrl};
    end else if (reg_addr_in == sarhc_pkg::REG_STATUS) begin
      reg_rdata_out <= {26'h000_0000, timeout, early, pend_write, pend_start,
                        (wake_cnt != 32'h0000_0000), (state != ST_IDLE)};
    end else if (reg_addr_in == sarhc_pkg::REG_OFFSET) begin
      reg_rdata_out <= {20'h0_0000, offset};
    end else if (reg_addr_in == sarhc_pkg::REG_RESULT) begin
      reg_rdata_out <= {17'h0_0000, result};
    end else if (reg_addr_in == sarhc_pkg::REG_COUNT) begin
      reg_rdata_out <= {16'h0000, count};
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  start_width_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $fell(sample_start_n_out) |-> !sample_start_n_out [*4] ##1 sample_start_n_out)
    else $error("start pulse width wrong");
  bus_drive_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    data_bus_oe_out |-> !write_strobe_n_out && !chip_select_n_out && read_strobe_n_out)
    else $error("bus driven outside write");
  read_guard_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !read_strobe_n_out |-> $past(busy_n) && sample_start_n_out)
    else $error("read during conversion");
  word_shape_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    data_bus_oe_out |-> data_bus_out[14:12] == 3'b000) else $error("offset upper bits set");
  strap_ok_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    iface_sel_hi_out != iface_sel_lo_out) else $error("illegal mode strap");
  light_ref_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    light_sleep_select_out |-> $past(ctrl[sarhc_pkg::CTRL_EXTREF]))
    else $error("light sleep on internal ref");
  quiet_gap_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(read_strobe_n_out) |-> sample_start_n_out [*4]) else $error("quiet gap too short");
  offset_reset_a: assert property (@(posedge clk_in) !resetn_in |=> offset == 12'h000)
    else $error("offset not zero after reset");
endmodule
`default_nettype wire

// *** rtl/sarhc_pkg.sv ***
// Shared constants for the converter host controller.
// Assumes a 200 MHz clock on the controller side.
package sarhc_pkg;
  // Clock period in picoseconds.
  localparam int unsigned CLK_PS = 5000;
  // Wait after leaving light sleep, ns.
  localparam int unsigned LIGHT_WAKE_NS = 300;
  localparam int unsigned LIGHT_WAKE_CYC = (LIGHT_WAKE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // Wait after leaving deep sleep with the internal reference, ms.
  localparam int unsigned DEEP_INT_MS = 500;
  localparam int unsigned DEEP_INT_CYC = (DEEP_INT_MS * 1000 * 1000) / 5 + 0;
  // Wait after leaving deep sleep with an external reference, us.
  localparam int unsigned DEEP_EXT_US = 80;
  localparam int unsigned DEEP_EXT_CYC = (DEEP_EXT_US * 1000 * 1000 + CLK_PS - 1) / CLK_PS;
  // Conversion time, ns, and the longest time busy may stay low.
  localparam int unsigned CONV_NS = 300;
  localparam int unsigned CONV_CYC = (CONV_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // Start pulse low width, quiet gap, bus access widths and conversion timeout in cycles.
  localparam int unsigned START_LOW_CYC = 4;
  localparam int unsigned QUIET_CYC = 4;
  localparam int unsigned STROBE_CYC = 4;
  localparam int unsigned TIMEOUT_CYC = 2 * CONV_CYC + 16;
  // Register offsets of the controller's own register port.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_OFFSET = 4'h2;
  localparam logic [3:0] REG_RESULT = 4'h3;
  localparam logic [3:0] REG_COUNT = 4'h4;
  // Control register field positions.
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_LIGHT = 1;
  localparam int unsigned CTRL_DEEP = 2;
  localparam int unsigned CTRL_SAT = 3;
  localparam int unsigned CTRL_DEFER = 4;
  localparam int unsigned CTRL_EXTREF = 5;
  localparam int unsigned CTRL_WROFS = 6;
  // Reset values.
  localparam logic [5:0] CTRL_RESET = 6'h28;
  localparam logic [11:0] OFFSET_RESET = 12'h000;
  // Legal offset limits.
  localparam int OFFSET_MIN = -1310;
  localparam int OFFSET_MAX = 1310;
endpackage

// *** rtl/sarhc_sync.sv ***
// Three-stage pin synchroniser with agreement of the last two stages.
// Assumes the input is asynchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module sarhc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Pin side and clean side.
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] clean_out
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // The first stage feeds only the second, to contain metastability.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change is accepted once two settled stages agree.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      clean_out <= '1;
    end else if (s2 == s3) begin
      clean_out <= s3;
    end
  end
endmodule
`default_nettype wire

// *** sim/sar_adc_parallel_ctrl_test.sv ***
// Self-checking bench for the host controller with a behavioural converter.
// Assumes the package, the design and the converter model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_parallel_ctrl_test;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext_ref = 1'b1;
  logic [14:0] flt = 15'h2aaa;
  logic signed [31:0] ain = 0;
  logic [11:0] ofs_e = 12'h000;
  logic [14:0] last = 15'h0000;
  int seed = 6179;
  int fails = 0;
  int check_count = 0;
  int n = 0;
  int ofs_t[10] = '{0, -1310, 1310, 1311, -512, 1024, -1311, 0, 256, -4};
  logic [5:0] ctl_t[10] = '{6'h28, 6'h20, 6'h28, 6'h20, 6'h38, 6'h30, 6'h38, 6'h28, 6'h30, 6'h20};
  logic [5:0] slp_c[3] = '{6'h28, 6'h28, 6'h08};
  logic [5:0] slp_s[3] = '{6'h02, 6'h04, 6'h04};
  logic [31:0] rdata;
  logic st_n, cs_n, rd_n, wr_n, lt, dp, sat, hi, lo, busy_n, oe, den;
  logic [14:0] dout, dq, bus;
  // The converter's drive wins over the host's; a released bus shows a changing pattern.
  assign bus = den ? dq : (oe ? dout : flt);
  initial forever #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) flt <= ~flt;
  sarhc_ctrl #(.DEEP_INT_WAIT(50), .DEEP_EXT_WAIT(20)) DUT (
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .sample_start_n_out(st_n),
    .busy_n_in(busy_n), .chip_select_n_out(cs_n), .read_strobe_n_out(rd_n),
    .write_strobe_n_out(wr_n), .light_sleep_select_out(lt), .deep_sleep_select_out(dp),
    .saturate_enable_out(sat), .iface_sel_hi_out(hi), .iface_sel_lo_out(lo),
    .data_bus_in(bus), .data_bus_out(dout), .data_bus_oe_out(oe));
  sarhc_dev_model #(.DEEP_INT_WAIT(50), .DEEP_EXT_WAIT(20)) dev (
    .clk_in(clk_in), .resetn_in(resetn_in), .ext_ref_in(ext_ref), .ain_in(ain),
    .data_in(bus), .start_n_in(st_n), .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .light_in(lt), .deep_in(dp), .sat_in(sat), .hi_in(hi), .lo_in(lo),
    .busy_n_out(busy_n), .data_out(dq), .data_en_out(den));
  // The host must never drive while the converter does.
  always @(posedge clk_in) if (resetn_in) chk(32'(oe & den), 32'h0000_0000);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Polls status until the model saw k conversions and the host is idle.
  task automatic wait_idle(input int k);
    logic [31:0] st;
    for (int i = 0; i < 3000; i++) begin
      rd_reg(sarhc_pkg::REG_STATUS, st);
      if (dev.nconv == k && st[3:0] == 4'h0) break;
    end
    chk(st & 32'h0000_0030, 32'h0000_0000);
    chk(32'(dev.nconv), 32'(k));
  endtask
  task automatic set_ofs(input int o);
    wr_reg(sarhc_pkg::REG_OFFSET, 32'(o));
    wr_reg(sarhc_pkg::REG_CTRL, 32'h0000_0068);
    if (o >= sarhc_pkg::OFFSET_MIN && o <= sarhc_pkg::OFFSET_MAX) ofs_e = 12'(o);
    wait_idle(n);
    chk(32'(dev.ofs), 32'(ofs_e));
  endtask
  // One conversion, optionally started while a sleep mode holds it back.
  task automatic convert(input logic [5:0] c, input logic [5:0] s, input int a);
    logic [31:0] d;
    logic [14:0] e;
    ain <= a;
    ext_ref <= c[5];
    wr_reg(sarhc_pkg::REG_CTRL, 32'(c | s | 6'h01));
    if (s != 6'h00) begin
      rd_reg(sarhc_pkg::REG_STATUS, d);
      chk(d & 32'h0000_0004, 32'h0000_0004);
      chk(32'({lt, dp}), 32'({s[1], s[2]}));
      wr_reg(sarhc_pkg::REG_CTRL, 32'(c));
    end
    n++;
    wait_idle(n);
    chk(32'({sat, hi, lo}), 32'({c[3], c[4], !c[4]}));
    rd_reg(sarhc_pkg::REG_RESULT, d);
    e = dev.conv(a, ofs_e, c[3]);
    chk(d, 32'(c[4] ? last : e));
    last = e;
  endtask
  task automatic wrap_up();
    chk(32'(dev.bad), 32'h0000_0000);
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    logic [31:0] d;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd_reg(sarhc_pkg::REG_CTRL, d);
    chk(d, 32'(sarhc_pkg::CTRL_RESET));
    rd_reg(sarhc_pkg::REG_RESULT, d);
    chk(d, 32'h0000_0000);
    rd_reg(4'hf, d);
    chk(d, 32'h0000_0000);
    chk(32'(dev.ofs), 32'h0000_0000);
    wr_reg(sarhc_pkg::REG_CTRL, 32'h0000_0002);
    rd_reg(sarhc_pkg::REG_CTRL, d);
    chk(d, 32'h0000_0000);
    for (int i = 0; i < 10; i++) begin
      set_ofs(ofs_t[i]);
      convert(ctl_t[i], 6'h00, $random(seed) % 9600 + 8100);
    end
    for (int i = 0; i < 3; i++) begin
      convert(slp_c[i], slp_s[i], $random(seed) % 9600 + 8100);
    end
    // Every finished conversion is counted once, and the last legal offset is kept.
    rd_reg(sarhc_pkg::REG_COUNT, d);
    chk(d, 32'(n));
    rd_reg(sarhc_pkg::REG_OFFSET, d);
    chk(d, 32'(ofs_e));
    wrap_up();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire

// *** sim/sarhc_dev_model.sv ***
// Behavioural converter that answers the host controller's pins.
// Assumes the host clock samples it and the bench resolves the data bus.
`timescale 1ns/1ps
`default_nettype none
module sarhc_dev_model #(
  parameter int DEEP_INT_WAIT = 50,
  parameter int DEEP_EXT_WAIT = 20,
  parameter int QUIET_MIN = 2
) (
  // Clock, reset and board setup.
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ext_ref_in,
  input wire logic signed [31:0] ain_in,
  input wire logic [14:0] data_in,
  // Pins from the host.
  input wire logic start_n_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic light_in,
  input wire logic deep_in,
  input wire logic sat_in,
  input wire logic hi_in,
  input wire logic lo_in,
  // Answers to the host.
  output logic busy_n_out,
  output logic [14:0] data_out,
  output logic data_en_out
);
  int cnt, since, quiet, req, bad, nconv, ain_q;
  logic [11:0] ofs;
  logic [14:0] done_q, wbuf;
  logic start_q, wr_q, deep_q;
  function automatic logic [14:0] conv(input int a, input logic [11:0] o, input logic s);
    int v;
    v = a + int'($signed(o));
    if (!s) return v[14:0];
    return {a < 0 || a > 16383, v < 0 ? 14'h0000 : (v > 16383 ? 14'h3fff : v[13:0])};
  endfunction
  assign data_en_out = !cs_n_in && !rd_n_in;
  // Pins are seen on the host clock, so every edge lands up to one cycle late.
  always @(posedge clk_in) begin
    start_q <= start_n_in;
    wr_q <= wr_n_in;
    if (!resetn_in) begin
      busy_n_out <= 1'b1;
      cnt <= 0;
      since <= 1000000;
      quiet <= 100;
      bad <= 0;
      nconv <= 0;
      deep_q <= 1'b0;
      ofs <= 12'h000;
      data_out <= 15'h0000;
      done_q <= 15'h0000;
    end else begin
      quiet <= (!cs_n_in || !rd_n_in || !wr_n_in) ? 0 : quiet + 1;
      req = deep_q ? (ext_ref_in ? DEEP_EXT_WAIT : DEEP_INT_WAIT) : sarhc_pkg::LIGHT_WAKE_CYC;
      if (light_in || deep_in) begin
        since <= 0;
        deep_q <= deep_in;
      end else if (since < 1000000) begin
        since <= since + 1;
      end
      if ((light_in && !ext_ref_in) || hi_in == lo_in || (!busy_n_out && data_en_out)) begin
        bad <= bad + 1;
      end
      // offset taken when the write strobe rises.
      if (!wr_n_in && !cs_n_in) wbuf <= data_in;
      if (!wr_q && wr_n_in) begin
        ofs <= wbuf[11:0];
        if (wbuf[14:12] != 3'h0) bad <= bad + 1;
      end
      if (start_q && !start_n_in && busy_n_out) begin
        busy_n_out <= 1'b0;
        cnt <= sarhc_pkg::CONV_CYC;
        ain_q <= ain_in;
        if (since + 2 < req || quiet < QUIET_MIN) bad <= bad + 1;
        if (hi_in) data_out <= done_q;
      end
      if (cnt == 1) begin
        busy_n_out <= 1'b1;
        done_q <= conv(ain_q, ofs, sat_in);
        nconv <= nconv + 1;
        if (lo_in) data_out <= conv(ain_q, ofs, sat_in);
      end
      if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire
